/* crosspoint_control_word.sv */
// Serial control word capture and global clamp, power and output enable logic
// Behaviour
// - Reset: outputs disabled, standby until control word
// - Control word needs top three bits ones
// - Bit nine enables input clamp
// - Bit one: standby zero, operational one
// - Global enable zero tri-states all outputs
// - Clamp setting applies to all inputs
// - Clamp zero turns clamp sources off
// - High insert select swaps in insertion video
// - Insert selects weakly pulled low
// - LSB-first shift on rising clock, commit on strobe
// - Individual enables ANDed with global enable
// - Control registers write-only, no readback
module crosspoint_control_word
   import crosspoint_pkg::*;
#(
   parameter int INPUTS = NUM_INPUTS,
   parameter int OUTPUTS = NUM_OUTPUTS
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic serialClk,
   input wire logic serial_word_in,
   input wire logic word_commit_strobe,
   input wire logic [OUTPUTS-1:0] insert_video_in,
   input wire logic [OUTPUTS-1:0] channelEnable,
   output logic chain_word_out,
   output logic [INPUTS-1:0] clampOn,
   output logic operational,
   output logic [OUTPUTS-1:0] outputDrive,
   output logic [OUTPUTS-1:0] insertActive
);
   if (INPUTS < 1 || OUTPUTS < 1) begin : gBadCount
      $error("crosspoint_control_word: bad channel counts");
   end

   // ****************************************
   // Pin synchronisation
   // ****************************************
   logic [2:0] serialSync;
   logic [OUTPUTS-1:0] insertSync;
   logic sclkS;
   logic sdiS;
   logic strobeS;

   pin_sync #(.WIDTH(3)) serialPins (
      .clk(clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .pinIn({word_commit_strobe, serial_word_in, serialClk}),
      .syncOut(serialSync)
   );

   // Sync stages reset low, standing in for the weak pull-down
   pin_sync #(.WIDTH(OUTPUTS)) insertPins (
      .clk(clk),
      .rstn(rstn),
      .clkEn(clkEn),
      .pinIn(insert_video_in),
      .syncOut(insertSync)
   );

   assign sclkS = serialSync[0];
   assign sdiS = serialSync[1];
   assign strobeS = serialSync[2];

   // ****************************************
   // Shift register and control word hold
   // ****************************************
   logic sclkPrev_reg, sclkPrev_next;
   logic strobePrev_reg, strobePrev_next;
   logic [WORD_WIDTH-1:0] shift_reg, shift_next;
   logic chainOut_reg, chainOut_next;
   logic clamp_reg, clamp_next;
   logic power_reg, power_next;
   logic globalOe_reg, globalOe_next;
   logic sclkRise, sclkFall, strobeRise, isControl;

   assign sclkRise = sclkS && !sclkPrev_reg;
   assign sclkFall = !sclkS && sclkPrev_reg;
   assign strobeRise = strobeS && !strobePrev_reg;
   assign isControl = shift_reg[CMD_MSB:CMD_LSB] == CMD_CONTROL;

   always_comb begin
      sclkPrev_next = sclkS;
      strobePrev_next = strobeS;
      shift_next = shift_reg;
      chainOut_next = chainOut_reg;
      clamp_next = clamp_reg;
      power_next = power_reg;
      globalOe_next = globalOe_reg;
      if (sclkRise) begin
         // First bit in ends up at bit 0 after sixteen clocks
         shift_next = {sdiS, shift_reg[WORD_WIDTH-1:1]};
      end
      if (sclkFall) begin
         // Chain output only replays shifted data; nothing reads back
         chainOut_next = shift_reg[0];
      end
      if (strobeRise && isControl) begin
         // Reserved bits are not checked; the host keeps them zero
         clamp_next = shift_reg[CLAMP_BIT];
         power_next = shift_reg[POWER_BIT];
         globalOe_next = shift_reg[GLOBAL_OE_BIT];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclkPrev_reg <= 1'h0;
         strobePrev_reg <= 1'h0;
         shift_reg <= SHIFT_RESET;
         chainOut_reg <= 1'h0;
         clamp_reg <= CLAMP_RESET;
         power_reg <= POWER_RESET;
         globalOe_reg <= GLOBAL_OE_RESET;
      end else if (clkEn) begin
         sclkPrev_reg <= sclkPrev_next;
         strobePrev_reg <= strobePrev_next;
         shift_reg <= shift_next;
         chainOut_reg <= chainOut_next;
         clamp_reg <= clamp_next;
         power_reg <= power_next;
         globalOe_reg <= globalOe_next;
      end
   end

   // ****************************************
   // Output stage controls
   // ****************************************
   logic [INPUTS-1:0] clampOn_reg, clampOn_next;
   logic [OUTPUTS-1:0] drive_reg, drive_next;
   logic [OUTPUTS-1:0] insert_reg, insert_next;

   // One clamp bit fans out to every input; no per-input control
   genvar gi;
   for (gi = 0; gi < INPUTS; gi++) begin : gClamp
      assign clampOn_next[gi] = clamp_reg;
   end

   always_comb begin
      drive_next = channelEnable & {OUTPUTS{globalOe_reg}};
      insert_next = insertSync;
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         clampOn_reg <= '0;
         drive_reg <= '0;
         insert_reg <= '0;
      end else if (clkEn) begin
         clampOn_reg <= clampOn_next;
         drive_reg <= drive_next;
         insert_reg <= insert_next;
      end
   end

   assign chain_word_out = chainOut_reg;
   assign clampOn = clampOn_reg;
   assign operational = power_reg;
   assign outputDrive = drive_reg;
   assign insertActive = insert_reg;

   // ****************************************
   // Assertions
   // ****************************************
   logic committed_reg;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         committed_reg <= 1'h0;
      end else if (clkEn && strobeRise && isControl) begin
         committed_reg <= 1'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   power_on_state_a: assert property (!committed_reg |-> !operational && outputDrive == '0)
      else $error("output or power active before any control word");
   other_cmd_kept_a: assert property (clkEn && strobeRise && !isControl
      |=> $stable(power_reg) && $stable(globalOe_reg) && $stable(clamp_reg))
      else $error("non-control word changed control state");
   clamp_field_a: assert property (clkEn && strobeRise && isControl
      |=> ##1 clampOn == {INPUTS{$past(shift_reg[CLAMP_BIT], 2)}})
      else $error("clamp output does not follow bit nine");
   power_field_a: assert property (clkEn && strobeRise && isControl
      |=> operational == $past(shift_reg[POWER_BIT]))
      else $error("power state does not follow bit one");
   global_gate_a: assert property (clkEn && !globalOe_reg |=> outputDrive == '0)
      else $error("output driven while global enable low");
   clamp_uniform_a: assert property (clampOn == '0 || clampOn == '1)
      else $error("clamp differs between inputs");
   clamp_off_a: assert property (clkEn && !clamp_reg |=> clampOn == '0)
      else $error("clamp sources on while clamp field zero");
   insert_follow_a: assert property (clkEn |=> insertActive == $past(insertSync))
      else $error("insert select not followed");
   shift_lsb_first_a: assert property (clkEn && sclkRise
      |=> shift_reg == {$past(sdiS), $past(shift_reg[WORD_WIDTH-1:1])})
      else $error("shift register did not take bit at top");
   enable_and_a: assert property (clkEn
      |=> outputDrive == ($past(channelEnable) & {OUTPUTS{$past(globalOe_reg)}}))
      else $error("output drive is not enable AND global");
   chain_replay_a: assert property (clkEn && sclkFall |=> chain_word_out == $past(shift_reg[0]))
      else $error("chain output not the shifted bit");
   // Nothing may drift between events, or a half-sent word would reach the outputs
   shift_hold_a: assert property (clkEn && !sclkRise |=> $stable(shift_reg))
      else $error("shift register moved without a serial clock rise");
   chain_hold_a: assert property (clkEn && !sclkFall |=> $stable(chain_word_out))
      else $error("chain output moved without a serial clock fall");
   control_hold_a: assert property (clkEn && !(strobeRise && isControl)
      |=> $stable(power_reg) && $stable(globalOe_reg) && $stable(clamp_reg))
      else $error("control state moved without a commit");

   operate_c: cover property (clkEn && strobeRise && isControl && shift_reg[POWER_BIT]);
   standby_c: cover property (clkEn && strobeRise && isControl && !shift_reg[POWER_BIT]);
   drive_c: cover property (outputDrive != '0);
   insert_c: cover property (insertActive != '0 && operational);
   clamp_off_c: cover property (operational && clampOn == '0);
endmodule

/* crosspoint_pkg.sv */
// Shared constants for the crosspoint global control word logic
package crosspoint_pkg;
   localparam int WORD_WIDTH = 16;
   localparam int NUM_INPUTS = 32;
   localparam int NUM_OUTPUTS = 16;
   localparam int SYNC_STAGES = 2;
   // Command field in the top three bits of each serial word
   localparam int CMD_MSB = 15;
   localparam int CMD_LSB = 13;
   localparam logic [2:0] CMD_CONTROL = 3'h7;
   // Control word field positions
   localparam int CLAMP_BIT = 9;
   localparam int POWER_BIT = 1;
   localparam int GLOBAL_OE_BIT = 0;
   // Power-on values: clamp off, standby, all outputs tri-stated
   localparam logic CLAMP_RESET = 1'h0;
   localparam logic POWER_RESET = 1'h0;
   localparam logic GLOBAL_OE_RESET = 1'h0;
   localparam logic [WORD_WIDTH-1:0] SHIFT_RESET = 16'h0000;
endpackage

/* pin_sync.sv */
// Two-stage synchroniser bank for asynchronous pin inputs
module pin_sync
   import crosspoint_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic clkEn,
   input wire logic [WIDTH-1:0] pinIn,
   output logic [WIDTH-1:0] syncOut
);
   if (WIDTH < 1 || SYNC_STAGES < 2) begin : gBadConfig
      $error("pin_sync: WIDTH must be at least 1 and SYNC_STAGES at least 2");
   end

   // Reset to zero: a floating pin reads as low until the pin settles
   genvar i;
   for (i = 0; i < WIDTH; i++) begin : gSync
      logic [SYNC_STAGES-1:0] stage_reg;
      logic [SYNC_STAGES-1:0] stage_next;
      always_comb begin
         stage_next = {stage_reg[SYNC_STAGES-2:0], pinIn[i]};
      end
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            stage_reg <= '0;
         end else if (clkEn) begin
            stage_reg <= stage_next;
         end
      end
      assign syncOut[i] = stage_reg[SYNC_STAGES-1];
   end
endmodule

/* host_serial.sv */
// Behavioural host that drives the three-wire serial configuration pins
module host_serial (
   input wire logic clk,
   output logic serialClk,
   output logic serialData,
   output logic strobe
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Idle levels
   // ****************************************
   // The serial clock rests low between frames; data rests at a level that differs from the last bit
   initial begin
      serialClk = 1'h0;
      serialData = 1'h0;
      strobe = 1'h0;
   end
   // ****************************************
   // Word transfer
   // ****************************************
   // Every level is held at least four clock cycles, which is more than the two the synchronisers need
   task automatic send(input logic [15:0] w);
      for (int i = 0; i < 16; i++) begin
         @(posedge clk);
         #10 serialData = w[i];
         repeat (4) @(posedge clk);
         #10 serialClk = 1'h1;
         repeat (4) @(posedge clk);
         #10 serialClk = 1'h0;
      end
      serialData = ~w[15];
      repeat (4) @(posedge clk);
      #10 strobe = 1'h1;
      repeat (4) @(posedge clk);
      #10 strobe = 1'h0;
   endtask
endmodule

/* tb.sv */
// Self-checking testbench for the global control word logic
module tb
   import crosspoint_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rstn, clkEn, serialClk, serialData, strobe, chainOut, operational;
   logic [15:0] insertSel, chanEn, outDrive, insActive;
   logic [31:0] clampOn;
   int mismatches = 0;
   int checksDone = 0;
   crosspoint_control_word u_crosspoint_control_word (.clk(clk), .rstn(rstn), .clkEn(clkEn),
      .serialClk(serialClk), .serial_word_in(serialData), .word_commit_strobe(strobe),
      .insert_video_in(insertSel), .channelEnable(chanEn), .chain_word_out(chainOut),
      .clampOn(clampOn), .operational(operational), .outputDrive(outDrive),
      .insertActive(insActive));
   host_serial u_host_serial (.clk(clk), .serialClk(serialClk), .serialData(serialData),
      .strobe(strobe));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checksDone++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic expectState(input logic op, input logic clamp, input logic [15:0] drv);
      chk({31'h0, operational}, {31'h0, op}, "operational");
      chk(clampOn, {32{clamp}}, "clamp");
      chk({16'h0, outDrive}, {16'h0, drv}, "output drive");
   endtask
   // Outputs settle four edges after the strobe rises; the host already spent all four of them
   task automatic sendWord(input logic [15:0] w);
      u_host_serial.send(w);
      repeat (3) @(posedge clk);
      #10;
   endtask
   task automatic endTest(input string name);
      $display("test %s done", name);
   endtask
   task automatic stopTest();
      $display("checks %0d mismatches %0d", checksDone, mismatches);
      if (mismatches == 0 && checksDone > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ****************************************
   // Clock and watchdog
   // ****************************************
   initial begin
      clk = 1'h0;
      forever #50 clk = ~clk;
   end
   // The whole sequence needs about a thousand cycles; five thousand leaves ample margin
   initial begin
      #500000;
      mismatches++;
      $display("mismatch at %0t: watchdog expired", $time);
      stopTest();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      rstn = 1'h0;
      clkEn = 1'h1;
      insertSel = 16'h0000;
      chanEn = 16'ha5c3;
      repeat (16) @(posedge clk);
      #10 rstn = 1'h1;
      @(posedge clk);
      #10;
      expectState(1'h0, 1'h0, 16'h0000);
      chk({16'h0, insActive}, 32'h0, "insert after reset");
      endTest("power_on");
      sendWord(16'he203);
      expectState(1'h1, 1'h1, 16'ha5c3);
      chk({31'h0, chainOut}, 32'h1, "chain bit");
      sendWord(16'h2000);
      expectState(1'h1, 1'h1, 16'ha5c3);
      endTest("control_commit");
      sendWord(16'he002);
      expectState(1'h1, 1'h0, 16'h0000);
      chk({31'h0, chainOut}, 32'h0, "chain bit");
      sendWord(16'he001);
      expectState(1'h0, 1'h0, 16'ha5c3);
      endTest("fields");
      chanEn = 16'h0f0f;
      @(posedge clk);
      #10 chk({16'h0, outDrive}, {16'h0, 16'h0f0f}, "drive follows enable");
      clkEn = 1'h0;
      chanEn = 16'hffff;
      repeat (2) @(posedge clk);
      #10 chk({16'h0, outDrive}, {16'h0, 16'h0f0f}, "drive frozen");
      clkEn = 1'h1;
      @(posedge clk);
      #10 chk({16'h0, outDrive}, {16'h0, 16'hffff}, "drive resumed");
      endTest("enable_gating");
      insertSel = 16'h8001;
      repeat (3) @(posedge clk);
      #10 chk({16'h0, insActive}, {16'h0, 16'h8001}, "insert on");
      insertSel = 16'h0000;
      repeat (3) @(posedge clk);
      #10 chk({16'h0, insActive}, 32'h0, "insert off");
      endTest("insertion");
      sendWord(16'he203);
      expectState(1'h1, 1'h1, 16'hffff);
      rstn = 1'h0;
      #20 expectState(1'h0, 1'h0, 16'h0000);
      @(posedge clk);
      #10 rstn = 1'h1;
      @(posedge clk);
      #10 expectState(1'h0, 1'h0, 16'h0000);
      chk({16'h0, insActive}, 32'h0, "insert after mid reset");
      sendWord(16'he203);
      expectState(1'h1, 1'h1, 16'hffff);
      endTest("mid_reset");
      stopTest();
   end
endmodule
